// ==== verilog/bzg_zone_gen.sv ====
`timescale 1ns/1ps
`include "bzg_cfg.svh"

module bzg_zone_gen import bzg_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bzg_cmd_t cmd,
  output logic cmd_error,
  output logic unit_valid,
  input wire logic unit_ready,
  output bzg_unit_t unit,
  output bzg_ctl_t ctl,
  output logic [11:0] zone_len,
  output logic zone_done
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bzg_state_t state;
  bzg_state_t next_state;
  bzg_cmd_t cmd_r;
  logic [11:0] loss_unit;
  logic [11:0] mark_unit;
  logic [11:0] len_c;
  logic [11:0] loss_c;
  logic [11:0] mark_c;
  logic [11:0] next_rel;
  bzg_kind_t map_kind;
  logic map_recorded;
  logic cmd_take;
  logic cmd_bad;
  logic unit_take;
  logic unit_last;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign cmd_ready = (state == BZG_S_IDLE);
  assign cmd_take = cmd_valid && cmd_ready;
  // Start sector range and block alignment check
  assign cmd_bad = (cmd.out_start <= `BZG_PSN_LIMIT) ||
                   ((cmd.out_start & `BZG_ALIGN_MASK) != 24'h000000);
  assign unit_valid = (state == BZG_S_EMIT);
  assign unit_take = unit_valid && unit_ready;
  assign unit_last = (unit.rel == zone_len - 12'h001);

  // ----------------------------------------------------------------
  // Sizing and unit content
  // ----------------------------------------------------------------
  bzg_zone_size u_size (
    .out_start(cmd_r.out_start),
    .next_start(cmd_r.next_start),
    .first_zone(cmd_r.first_zone),
    .zone_len(len_c),
    .loss_unit(loss_c),
    .mark_unit(mark_c)
  );

  // Position of the unit to be loaded next
  always_comb begin
    if (state == BZG_S_EMIT) begin
      next_rel = unit.rel + 12'h001;
    end else begin
      next_rel = 12'h000;
    end
  end

  bzg_unit_map u_map (
    .rel(next_rel),
    .mark_unit(mark_unit),
    .loss_unit(loss_unit),
    .next_present(cmd_r.next_present),
    .kind(map_kind),
    .recorded(map_recorded)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      BZG_S_IDLE: begin
        if (cmd_take && !cmd_bad) begin
          next_state = BZG_S_SIZE;
        end
      end
      BZG_S_SIZE: begin
        next_state = BZG_S_LOAD;
      end
      BZG_S_LOAD: begin
        next_state = BZG_S_EMIT;
      end
      BZG_S_EMIT: begin
        if (unit_take && unit_last) begin
          next_state = BZG_S_IDLE;
        end
      end
      default: begin
        next_state = BZG_S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= BZG_S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latched request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_r <= '0;
    end else if (cmd_take && !cmd_bad) begin
      cmd_r <= cmd;
    end
  end

  // Refusal pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= cmd_take && cmd_bad;
    end
  end

  // Zone geometry, captured once per zone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      zone_len <= 12'h000;
      loss_unit <= 12'h000;
      mark_unit <= 12'h000;
    end else if (state == BZG_S_SIZE) begin
      zone_len <= len_c;
      loss_unit <= loss_c;
      mark_unit <= mark_c;
    end
  end

  // Control-data words for the border-in copies
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl <= '0;
    end else if (state == BZG_S_SIZE) begin
      ctl.out_start <= {8'h00, cmd_r.out_start};
      ctl.next_start <= {8'h00, cmd_r.next_start};
    end
  end

  // Unit descriptor, one block per position
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unit <= '0;
    end else if (state == BZG_S_LOAD || (unit_take && !unit_last)) begin
      unit.kind <= map_kind;
      unit.recorded <= map_recorded;
      unit.rel <= next_rel;
      unit.psn <= cmd_r.out_start + {8'h00, next_rel, 4'h0};
    end
  end

  // Zone finished pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      zone_done <= 1'b0;
    end else begin
      zone_done <= unit_take && unit_last;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  logic emit_now;
  logic [11:0] mark_d;
  assign emit_now = (state == BZG_S_EMIT);
  assign mark_d = unit.rel - mark_unit;

  // Last marker unit handed over
  sequence last_mark_taken;
    unit_take && unit.kind == BZG_K_MARK && mark_d == 12'h015;
  endsequence

  // Loss guard shown in the following cycle
  sequence loss_guard_next;
    ##1 (unit.kind == BZG_K_LOSS && unit.rel == mark_unit + 12'h016);
  endsequence

  first_low_a: assert property (
    state == BZG_S_LOAD && cmd_r.first_zone && cmd_r.out_start < 24'h09DB00
    |-> zone_len == 12'h400)
    else $error("first zone low class length wrong");

  class_top_a: assert property (
    state == BZG_S_LOAD && !cmd_r.first_zone && cmd_r.out_start >= 24'h134300
    |-> zone_len == 12'h240)
    else $error("later zone top class length wrong");

  class_mid_a: assert property (
    state == BZG_S_LOAD && !cmd_r.first_zone && cmd_r.out_start >= 24'h09DB00
    && cmd_r.out_start < 24'h134300 |-> zone_len == 12'h180)
    else $error("later zone mid class length wrong");

  low_reject_a: assert property (
    cmd_take && cmd.out_start <= 24'h03D6FF
    |=> cmd_error && state == BZG_S_IDLE)
    else $error("low start sector not refused");

  align_reject_a: assert property (
    cmd_take && cmd.out_start[3:0] != 4'h0 |=> cmd_error ##1 state == BZG_S_IDLE)
    else $error("unaligned start sector not refused");

  unit_step_a: assert property (
    unit_take && !unit_last |=> unit.rel == $past(unit.rel) + 12'h001
    && unit.psn == $past(unit.psn) + 24'h000010)
    else $error("unit did not advance by one block");

  rmr_head_a: assert property (
    emit_now && unit.rel <= 12'h004 |-> unit.kind == BZG_K_RMR)
    else $error("management record copy missing");

  stop_pair_a: assert property (
    emit_now && (unit.rel == 12'h025 || unit.rel == 12'h026) |-> unit.kind == BZG_K_STOP)
    else $error("stop block misplaced");

  zero_fill_a: assert property (
    emit_now && unit.rel >= 12'h005 && unit.rel < mark_unit && unit.rel != 12'h025
    && unit.rel != 12'h026 |-> unit.kind == BZG_K_ZERO)
    else $error("zero fill missing before markers");

  mark_place_a: assert property (
    emit_now && unit.kind == BZG_K_MARK |-> mark_d == 12'h000 || mark_d == 12'h001
    || mark_d == 12'h00A || mark_d == 12'h00B || mark_d == 12'h014 || mark_d == 12'h015)
    else $error("marker at wrong position");

  mark_rec_a: assert property (
    emit_now && unit.kind == BZG_K_MARK |-> unit.recorded == cmd_r.next_present)
    else $error("marker recording flag wrong");

  guard_loss_a: assert property (
    last_mark_taken and cmd_r.next_present |-> loss_guard_next)
    else $error("guard after marker not linking loss");

  n_loss_a: assert property (
    emit_now && unit.rel == zone_len - 12'h007 |-> unit.kind == BZG_K_LOSS)
    else $error("unit N not linking loss");

  ctl_copy_a: assert property (
    emit_now && unit.rel > loss_unit && unit.rel <= loss_unit + 12'h005
    |-> unit.kind == BZG_K_CTL && ctl.out_start[23:0] == cmd_r.out_start
    && ctl.next_start[23:0] == cmd_r.next_start)
    else $error("control data copy wrong");

  end_guard_a: assert property (
    emit_now && unit.rel == zone_len - 12'h001
    |-> unit.kind == (cmd_r.next_present ? BZG_K_LOSS : BZG_K_GUARD))
    else $error("final guard wrong");

  last_unit_a: assert property (
    unit_take && unit.rel == loss_unit + 12'h006 |=> zone_done && state == BZG_S_IDLE)
    else $error("zone did not end after N plus six");

  mark_clamp_a: assert property (
    state == BZG_S_LOAD |-> mark_unit >= 12'h027 && mark_unit + 12'h017 <= loss_unit)
    else $error("marker unit outside zone");

  // Request taken and not refused
  sequence zone_accept;
    cmd_take && !cmd_bad;
  endsequence

  // Two quiet cycles, then unit 0 offered
  sequence first_unit_shown;
    !cmd_ready && !unit_valid ##1 !cmd_ready && !unit_valid
    ##1 unit_valid && unit.rel == 12'h000 && unit.kind == BZG_K_RMR;
  endsequence

  accept_walk_a: assert property (
    zone_accept |=> first_unit_shown)
    else $error("accepted zone did not start with unit zero");

  first_mid_a: assert property (
    state == BZG_S_LOAD && cmd_r.first_zone && cmd_r.out_start >= `BZG_CLASS_MID
    && cmd_r.out_start < `BZG_CLASS_TOP |-> zone_len == `BZG_FIRST_MID)
    else $error("first zone mid class length wrong");

  first_top_a: assert property (
    state == BZG_S_LOAD && cmd_r.first_zone && cmd_r.out_start >= `BZG_CLASS_TOP
    |-> zone_len == `BZG_FIRST_TOP)
    else $error("first zone top class length wrong");

  later_low_a: assert property (
    state == BZG_S_LOAD && !cmd_r.first_zone && cmd_r.out_start < `BZG_CLASS_MID
    |-> zone_len == `BZG_OTHER_LOW)
    else $error("later zone low class length wrong");

  unit_hold_a: assert property (
    unit_valid && !unit_ready |=> unit_valid && $stable(unit))
    else $error("unit changed while stalled");

  psn_align_a: assert property (
    emit_now |-> (unit.psn & `BZG_ALIGN_MASK) == 24'h000000)
    else $error("unit not on block boundary");

  ctl_hold_a: assert property (
    emit_now |-> $stable(ctl))
    else $error("control data changed inside zone");

  guard_plain_a: assert property (
    emit_now && !cmd_r.next_present && (mark_d == `BZG_GUARD_OFS
    || mark_d == `BZG_GUARD_OFS + `BZG_MARK_STEP
    || mark_d == `BZG_GUARD_OFS + `BZG_MARK_STEP + `BZG_MARK_STEP)
    |-> unit.kind == BZG_K_GUARD)
    else $error("guard without markers not plain guard");

  done_pulse_a: assert property (
    zone_done |-> cmd_ready && !unit_valid ##1 !zone_done)
    else $error("zone done not a single pulse");

endmodule // bzg_zone_gen

// ==== verilog/bzg_cfg.svh ====
`ifndef BZG_CFG_SVH
`define BZG_CFG_SVH

// ----------------------------------------------------------------
// Sector addressing
// ----------------------------------------------------------------
`define BZG_PSN_W 24
`define BZG_UNIT_W 12
`define BZG_PSN_LIMIT 24'h03D6FF
`define BZG_CLASS_MID 24'h09DB00
`define BZG_CLASS_TOP 24'h134300
`define BZG_SECT_SHIFT 4
`define BZG_ALIGN_MASK 24'h00000F

// ----------------------------------------------------------------
// Zone lengths in units
// ----------------------------------------------------------------
`define BZG_FIRST_LOW 12'h400
`define BZG_FIRST_MID 12'h800
`define BZG_FIRST_TOP 12'hC00
`define BZG_OTHER_LOW 12'h0C0
`define BZG_OTHER_MID 12'h180
`define BZG_OTHER_TOP 12'h240

// ----------------------------------------------------------------
// Unit layout
// ----------------------------------------------------------------
`define BZG_RMR_LAST 12'h004
`define BZG_ZERO_A_LAST 12'h024
`define BZG_STOP_LAST 12'h026
`define BZG_MARK_MIN 12'h027
`define BZG_MARK_SPAN 12'h017
`define BZG_MARK_STEP 12'h00A
`define BZG_GUARD_OFS 12'h002
`define BZG_TAIL_UNITS 12'h007
`define BZG_CTL_LAST_OFS 12'h005
`define BZG_END_OFS 12'h006

`endif

// ==== verilog/bzg_pkg.sv ====
package bzg_pkg;

  // Content class of one unit (one full error-correction block)
  typedef enum logic [2:0] {
    BZG_K_RMR = 3'h0,
    BZG_K_ZERO = 3'h1,
    BZG_K_STOP = 3'h2,
    BZG_K_MARK = 3'h3,
    BZG_K_GUARD = 3'h4,
    BZG_K_LOSS = 3'h5,
    BZG_K_CTL = 3'h6
  } bzg_kind_t;

  // Zone request from the formatter
  typedef struct packed {
    logic [23:0] out_start;
    logic [23:0] next_start;
    logic first_zone;
    logic next_present;
  } bzg_cmd_t;

  // One emitted unit
  typedef struct packed {
    bzg_kind_t kind;
    logic recorded;
    logic [11:0] rel;
    logic [23:0] psn;
  } bzg_unit_t;

  // Control-data words, bytes 32..35 and 36..39
  typedef struct packed {
    logic [31:0] out_start;
    logic [31:0] next_start;
  } bzg_ctl_t;

  // Sequencer states
  typedef enum logic [3:0] {
    BZG_S_IDLE = 4'b0001,
    BZG_S_SIZE = 4'b0010,
    BZG_S_LOAD = 4'b0100,
    BZG_S_EMIT = 4'b1000
  } bzg_state_t;

endpackage

// ==== verilog/bzg_zone_size.sv ====
`timescale 1ns/1ps
`include "bzg_cfg.svh"

// Size class, zone length, N and marker unit M
module bzg_zone_size import bzg_pkg::*; (
  input wire logic [23:0] out_start,
  input wire logic [23:0] next_start,
  input wire logic first_zone,
  output logic [11:0] zone_len,
  output logic [11:0] loss_unit,
  output logic [11:0] mark_unit
);
  logic [24:0] sum;
  logic [23:0] mid_psn;
  logic [23:0] rel_sect;
  logic [19:0] m_raw;
  logic [11:0] m_hi;

  // Zone length from class and order
  always_comb begin
    if (out_start < `BZG_CLASS_MID) begin
      zone_len = first_zone ? `BZG_FIRST_LOW : `BZG_OTHER_LOW;
    end else if (out_start < `BZG_CLASS_TOP) begin
      zone_len = first_zone ? `BZG_FIRST_MID : `BZG_OTHER_MID;
    end else begin
      zone_len = first_zone ? `BZG_FIRST_TOP : `BZG_OTHER_TOP;
    end
  end

  // Marker midpoint and its unit offset, clamped into the zone
  always_comb begin
    loss_unit = zone_len - `BZG_TAIL_UNITS;
    sum = {1'b0, out_start} + {1'b0, next_start};
    mid_psn = sum[24:1];
    rel_sect = (next_start > out_start) ? (mid_psn - out_start) : 24'h000000;
    m_raw = rel_sect[23:`BZG_SECT_SHIFT];
    m_hi = loss_unit - `BZG_MARK_SPAN;
    if (m_raw < {8'h00, `BZG_MARK_MIN}) begin
      mark_unit = `BZG_MARK_MIN;
    end else if (m_raw > {8'h00, m_hi}) begin
      mark_unit = m_hi;
    end else begin
      mark_unit = m_raw[11:0];
    end
  end
endmodule // bzg_zone_size

// ==== verilog/bzg_unit_map.sv ====
`timescale 1ns/1ps
`include "bzg_cfg.svh"

// Content of one relative unit position
module bzg_unit_map import bzg_pkg::*; (
  input wire logic [11:0] rel,
  input wire logic [11:0] mark_unit,
  input wire logic [11:0] loss_unit,
  input wire logic next_present,
  output bzg_kind_t kind,
  output logic recorded
);
  logic [11:0] d;
  bzg_kind_t guard_kind;

  always_comb begin
    d = rel - mark_unit;
    // Guard becomes linking loss once markers are written
    guard_kind = next_present ? BZG_K_LOSS : BZG_K_GUARD;
    recorded = 1'b1;
    if (rel <= `BZG_RMR_LAST) begin
      kind = BZG_K_RMR;
    end else if (rel <= `BZG_ZERO_A_LAST) begin
      kind = BZG_K_ZERO;
    end else if (rel <= `BZG_STOP_LAST) begin
      kind = BZG_K_STOP;
    end else if (rel < mark_unit) begin
      kind = BZG_K_ZERO;
    end else if (d < `BZG_MARK_SPAN) begin
      if (d == 12'h000 || d == 12'h001 || d == `BZG_MARK_STEP ||
          d == `BZG_MARK_STEP + 12'h001 || d == `BZG_MARK_STEP + `BZG_MARK_STEP ||
          d == `BZG_MARK_STEP + `BZG_MARK_STEP + 12'h001) begin
        kind = BZG_K_MARK;
        recorded = next_present;
      end else if (d == `BZG_GUARD_OFS || d == `BZG_GUARD_OFS + `BZG_MARK_STEP ||
                   d == `BZG_GUARD_OFS + `BZG_MARK_STEP + `BZG_MARK_STEP) begin
        kind = guard_kind;
      end else begin
        kind = BZG_K_ZERO;
      end
    end else if (rel < loss_unit) begin
      kind = BZG_K_ZERO;
    end else if (rel == loss_unit) begin
      kind = BZG_K_LOSS;
    end else if (rel <= loss_unit + `BZG_CTL_LAST_OFS) begin
      kind = BZG_K_CTL;
    end else begin
      kind = guard_kind;
    end
  end
endmodule // bzg_unit_map

// ==== test/bzg_unit_sink.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Formatter model taking units from the zone generator
// ----------------------------------------------------------------
module bzg_unit_sink import bzg_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic unit_valid,
  output logic unit_ready,
  input wire bzg_unit_t unit
);
  bzg_unit_t seen [0:4095];
  int count;
  int order_errors;

  // Always ready, or ready every other cycle to stall the stream
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unit_ready <= 1'b0;
    end else begin
      unit_ready <= slow ? ~unit_ready : 1'b1;
    end
  end

  // One accepted unit is one whole block, stored by position
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 0;
      order_errors <= 0;
    end else if (unit_valid && unit_ready) begin
      seen[unit.rel] <= unit;
      if (unit.rel == 12'h000) begin
        count <= 1;
      end else begin
        if (unit.rel != count[11:0]) begin
          order_errors <= order_errors + 1;
        end
        count <= count + 1;
      end
    end
  end
endmodule // bzg_unit_sink

// ==== test/test_border_zone_layout_generator.sv ====
`timescale 1ns/1ps

module test_border_zone_layout_generator import bzg_pkg::*; ;
  logic sys_clk;
  logic resetn;
  logic cmd_valid;
  logic cmd_ready;
  bzg_cmd_t cmd;
  logic cmd_error;
  logic unit_valid;
  logic unit_ready;
  bzg_unit_t unit;
  bzg_ctl_t ctl;
  logic [11:0] zone_len;
  logic zone_done;
  logic slow;
  int errors;
  int compares;

  // ----------------------------------------------------------------
  // Design and formatter model
  // ----------------------------------------------------------------
  bzg_zone_gen bzg_zone_gen_inst (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .cmd_error(cmd_error), .unit_valid(unit_valid), .unit_ready(unit_ready),
    .unit(unit), .ctl(ctl), .zone_len(zone_len), .zone_done(zone_done)
  );
  bzg_unit_sink bzg_unit_sink_inst (
    .sys_clk(sys_clk), .resetn(resetn), .slow(slow), .unit_valid(unit_valid),
    .unit_ready(unit_ready), .unit(unit)
  );

  // Clock, 10 ns period
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Present one request for one edge, return mid cycle after it
  task automatic issue(input logic [23:0] o, input logic [23:0] nx, input logic f,
                       input logic np);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '{out_start: o, next_start: nx, first_zone: f, next_present: np};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
  endtask

  // Expected content of unit r
  function automatic bzg_kind_t exp_kind(input int r, input int m, input int n,
                                         input logic np);
    int d;
    bzg_kind_t g;
    d = r - m;
    g = np ? BZG_K_LOSS : BZG_K_GUARD;
    if (r <= 4) return BZG_K_RMR;
    if (r <= 36) return BZG_K_ZERO;
    if (r <= 38) return BZG_K_STOP;
    if (d == 0 || d == 1 || d == 10 || d == 11 || d == 20 || d == 21) return BZG_K_MARK;
    if (d == 2 || d == 12 || d == 22) return g;
    if (r < n) return BZG_K_ZERO;
    if (r == n) return BZG_K_LOSS;
    if (r <= n + 5) return BZG_K_CTL;
    return g;
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    @(negedge sys_clk);
    check(64'(cmd_ready), 64'h1);
    check(64'({unit_valid, cmd_error, zone_done}), 64'h0);
  endtask

  // Refused request pulses error for one cycle and stays idle
  task automatic test_refuse(input logic [23:0] o);
    issue(o, o + 24'h000100, 1'b0, 1'b1);
    check(64'(cmd_error), 64'h1);
    check(64'(cmd_ready), 64'h1);
    @(negedge sys_clk);
    check(64'({cmd_error, unit_valid}), 64'h0);
  endtask

  // One whole zone, then every unit is judged
  task automatic test_zone(input logic [23:0] o, input logic [23:0] nx, input logic f,
                           input logic np, input logic s, input logic [11:0] len);
    int n;
    int m;
    int k;
    bzg_unit_t u;
    @(posedge sys_clk);
    slow <= s;
    issue(o, nx, f, np);
    check(64'({cmd_ready, cmd_error}), 64'h0);
    @(negedge sys_clk);
    check(64'(zone_len), 64'(len));
    check(64'(ctl.out_start), 64'(o));
    check(64'(ctl.next_start), 64'(nx));
    for (k = 0; k < 8000 && zone_done !== 1'b1; k++) @(negedge sys_clk);
    check(64'({zone_done, cmd_ready, unit_valid}), 64'h6);
    n = int'(len) - 7;
    m = (nx > o) ? ((int'(o) + int'(nx)) / 2 - int'(o)) / 16 : 0;
    m = (m < 39) ? 39 : (m > n - 23) ? n - 23 : m;
    for (k = 0; k < int'(len); k++) begin
      u = bzg_unit_sink_inst.seen[k];
      check(64'(u.kind), 64'(exp_kind(k, m, n, np)));
      check(64'(u.psn), 64'(o + 24'(16 * k)));
      if (k - m == 0 || k - m == 11 || k - m == 20) check(64'(u.recorded), 64'(np));
    end
    check(64'(bzg_unit_sink_inst.count), 64'(len));
    check(64'(bzg_unit_sink_inst.order_errors), 64'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset();
    test_refuse(24'h03D6FF);
    test_refuse(24'h03D6F0);
    test_refuse(24'h03D708);
    test_zone(24'h03D700, 24'h03E380, 1'b1, 1'b1, 1'b0, 12'h400);
    test_zone(24'h09DAF0, 24'h000000, 1'b0, 1'b0, 1'b0, 12'h0C0);
    test_zone(24'h09DB00, 24'h19DB00, 1'b0, 1'b1, 1'b0, 12'h180);
    test_zone(24'h1342F0, 24'h1344F0, 1'b1, 1'b0, 1'b0, 12'h800);
    test_zone(24'h134300, 24'h135300, 1'b0, 1'b1, 1'b1, 12'h240);
    test_zone(24'h134300, 24'h137300, 1'b1, 1'b0, 1'b1, 12'hC00);
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    errors++;
    $display("ERROR at %0t: watchdog %0h expected %0h", $time, 1'b1, 1'b0);
    complete_run();
  end
endmodule // test_border_zone_layout_generator
